// ### rtl/arbr_consts.vh
// Function
// RULE_01 - After reset the word reads full flag clear and empty flag set.
// RULE_02 - Result word is read-only and fills only while buffer mode is on.
// RULE_03 - In buffer mode every finished result is stored, never dropped; the code overwrites a staged result if its source repeats.
// RULE_04 - Twelve-bit result sits right-justified in bits 11 to 0.
// RULE_05 - Buffer holds 64 entries; full flag set when all 64 are unread.
// RULE_06 - Empty flag shows in the word returned by reading the last entry.
// RULE_07 - Bit 13 is reserved with no defined value.
// RULE_08 - Tag is 0 for X, first pressure, battery and second auxiliary.
// RULE_09 - Tag is 1 for Y, second pressure, first auxiliary and temperature.
// RULE_10 - Two-axis stores Y then X; four-value stores Y, X, pressures.
// RULE_11 - Pressure-only stores first pressure before second pressure.
// RULE_12 - Auto scan stores selected inputs: aux one, aux two, temperature.
// RULE_13 - Port scan stores battery, then aux one, then aux two.
// RULE_14 - Each read returns and removes the oldest entry; full clears on read.
`ifndef ARBR_CONSTS_VH
`define ARBR_CONSTS_VH

// ==========================================
// Register map (byte addresses)
`define ARBR_ADDR_RESULT 12'h000
`define ARBR_ADDR_CTRL 12'h004
`define ARBR_ADDR_STATUS 12'h008
`define ARBR_ADDR_MASK 12'h00C
`define ARBR_ADDR_LEVEL 12'h010

// ==========================================
// Result word layout
`define ARBR_FULL_BIT 15
`define ARBR_EMPTY_BIT 14
`define ARBR_RSVD_BIT 13
`define ARBR_TAG_BIT 12
`define ARBR_WORD_RESET 16'h4000
`define ARBR_DEPTH 7'h40
`define ARBR_CTRL_MODE_BIT 0

// ==========================================
// Interrupt status bits
`define ARBR_IRQ_PUSH 0
`define ARBR_IRQ_FULL 1
`define ARBR_IRQ_DRAIN 2
`define ARBR_IRQ_LOST 3

// ==========================================
// Result sources
`define ARBR_SRC_X 3'h0
`define ARBR_SRC_Y 3'h1
`define ARBR_SRC_PRESS_ONE 3'h2
`define ARBR_SRC_PRESS_TWO 3'h3
`define ARBR_SRC_BATT 3'h4
`define ARBR_SRC_AUX_ONE 3'h5
`define ARBR_SRC_AUX_TWO 3'h6
`define ARBR_SRC_TEMP 3'h7

// ==========================================
// Conversion types
`define ARBR_CONV_SINGLE 3'h0
`define ARBR_CONV_XY 3'h1
`define ARBR_CONV_XYZZ 3'h2
`define ARBR_CONV_ZZ 3'h3
`define ARBR_CONV_AUTO 3'h4
`define ARBR_CONV_PORT 3'h5

// ==========================================
// Store order, three bits per slot, slot 0 in the low bits
`define ARBR_ORDER_SINGLE 24'hFAC688
`define ARBR_ORDER_XY 24'hFAC681
`define ARBR_ORDER_ZZ 24'hFAC21A
`define ARBR_ORDER_AUTO 24'h8D11F5
`define ARBR_ORDER_PORT 24'hED11AC

`endif

// ### rtl/arbr_mem.v
`timescale 1ns/1ps
`default_nettype none

module arbr_mem (
    // Clock
    input wire pclk,
    input wire ce,
    // Write port
    input wire wr_en,
    input wire [5:0] wr_addr,
    input wire [12:0] wr_data,
    // Read port
    input wire [5:0] rd_addr,
    output reg [12:0] rd_data
);

    reg [12:0] mem [0:63];

    // Registered read, no reset: contents are undefined until written
    always @(posedge pclk) begin
        if (ce) begin
            if (wr_en) begin
                mem[wr_addr] <= wr_data;
            end
            rd_data <= mem[rd_addr];
        end
    end

endmodule

`default_nettype wire

// ### rtl/arbr_top.v
// The APB register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "arbr_consts.vh"

module arbr_top (
    // Clock and reset
    input wire pclk,
    input wire presetn,
    input wire ce,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // Converter result stream
    input wire res_valid,
    input wire [2:0] res_source,
    input wire [11:0] res_value,
    input wire [2:0] conv_type,
    input wire conv_done,
    output reg conv_ready,
    // Interrupt
    output reg irq
);

    // ==========================================
    // Helpers
    function src_tag;
        input [2:0] src;
        begin
            case (src)
                `ARBR_SRC_Y, `ARBR_SRC_PRESS_TWO, `ARBR_SRC_AUX_ONE, `ARBR_SRC_TEMP: begin
                    src_tag = 1'b1; // RULE_09
                end
                default: src_tag = 1'b0; // RULE_08
            endcase
        end
    endfunction

    function [2:0] order_src;
        input [2:0] ctype;
        input [2:0] idx;
        reg [23:0] seq;
        begin
            case (ctype)
                `ARBR_CONV_XY: seq = `ARBR_ORDER_XY; // RULE_10
                `ARBR_CONV_XYZZ: seq = `ARBR_ORDER_XY; // RULE_10
                `ARBR_CONV_ZZ: seq = `ARBR_ORDER_ZZ; // RULE_11
                `ARBR_CONV_AUTO: seq = `ARBR_ORDER_AUTO; // RULE_12
                `ARBR_CONV_PORT: seq = `ARBR_ORDER_PORT; // RULE_13
                default: seq = `ARBR_ORDER_SINGLE;
            endcase
            order_src = seq[idx*3 +: 3];
        end
    endfunction

    // One-hot register select, shared by the write strobes and the read pop
    function [4:0] addr_hit;
        input [11:0] addr;
        begin
            addr_hit = 5'h00;
            case (addr)
                `ARBR_ADDR_RESULT: addr_hit = 5'h01;
                `ARBR_ADDR_CTRL: addr_hit = 5'h02;
                `ARBR_ADDR_STATUS: addr_hit = 5'h04;
                `ARBR_ADDR_MASK: addr_hit = 5'h08;
                `ARBR_ADDR_LEVEL: addr_hit = 5'h10;
                default: addr_hit = 5'h00;
            endcase
        end
    endfunction

    // ==========================================
    // State
    localparam [1:0] AP_IDLE = 2'h0;
    localparam [1:0] AP_WAIT = 2'h1;
    localparam [1:0] AP_FETCH = 2'h2;
    localparam [1:0] AP_DONE = 2'h3;
    localparam ST_COLLECT = 1'b0;
    localparam ST_FLUSH = 1'b1;

    reg [1:0] ap_phase;
    reg fl_state;
    reg [2:0] fl_idx;
    reg [2:0] fl_type;
    reg mode_en;
    reg [3:0] irq_status;
    reg [3:0] irq_mask;
    reg [5:0] wr_ptr;
    reg [5:0] rd_ptr;
    reg [6:0] count;
    reg [7:0] slot_valid;
    wire [12:0] mem_rdata;
    wire [11:0] slot_value [0:7];

    // ==========================================
    // Staging slots, one per source
    wire accept = res_valid & conv_ready & mode_en; // RULE_02
    wire [7:0] slot_clear;

    genvar g;
    generate
        for (g = 0; g < 8; g = g + 1) begin : g_slot
            reg [11:0] value;
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    value <= 12'h000;
                end else if (ce && accept && res_source == g) begin
                    value <= res_value; // RULE_03
                end
            end
            assign slot_value[g] = value;
        end
    endgenerate

    // ==========================================
    // Flush sequencer
    wire [2:0] fl_src = order_src(fl_type, fl_idx);
    wire fl_has = slot_valid[fl_src];
    wire fl_full = (count == `ARBR_DEPTH);
    // Pushes pause while a read is in flight so the popped word stays coherent
    wire push = (fl_state == ST_FLUSH) && fl_has && !fl_full && (ap_phase == AP_IDLE); // RULE_03
    wire fl_step = (fl_state == ST_FLUSH) && (!fl_has || push);
    wire fl_last = fl_step && (fl_idx == 3'h7);
    wire start = (fl_state == ST_COLLECT) && conv_done;
    wire next_ready = fl_state == ST_COLLECT ? !start : fl_last;
    wire [12:0] push_word = {src_tag(fl_src), slot_value[fl_src]}; // RULE_04

    assign slot_clear = push ? (8'h01 << fl_src) : 8'h00;

    // Ready drops the cycle after conv_done and returns the cycle after the last slot step

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fl_state <= ST_COLLECT;
            fl_idx <= 3'h0;
            fl_type <= `ARBR_CONV_SINGLE;
            slot_valid <= 8'h00;
            conv_ready <= 1'b0;
        end else if (ce) begin
            conv_ready <= next_ready;
            slot_valid <= (slot_valid & ~slot_clear) | (accept ? (8'h01 << res_source) : 8'h00);
            case (fl_state)
                ST_COLLECT: begin
                    if (start) begin
                        fl_state <= ST_FLUSH;
                        fl_idx <= 3'h0;
                        fl_type <= conv_type;
                    end
                end
                ST_FLUSH: begin
                    if (fl_last) begin
                        fl_state <= ST_COLLECT;
                    end else if (fl_step) begin
                        fl_idx <= fl_idx + 3'h1;
                    end
                end
                default: fl_state <= ST_COLLECT;
            endcase
        end
    end

    // ==========================================
    // Result memory
    // Registered read adds a cycle; the three APB wait states cover it
    arbr_mem arbr_mem_inst (
        .pclk(pclk),
        .ce(ce),
        .wr_en(push),
        .wr_addr(wr_ptr),
        .wr_data(push_word),
        .rd_addr(rd_ptr),
        .rd_data(mem_rdata)
    );

    // ==========================================
    // APB access
    wire [4:0] hit = addr_hit(paddr);
    wire is_read_result = !pwrite && hit[0];
    wire fetch = (ap_phase == AP_FETCH);
    wire pop = fetch && is_read_result && (count != 7'h00); // RULE_14
    wire [6:0] count_after = count - {6'h00, pop};
    wire wr_ctrl = fetch && pwrite && hit[1];
    wire wr_stat = fetch && pwrite && hit[2];
    wire wr_mask = fetch && pwrite && hit[3];
    reg [15:0] res_word;
    reg [31:0] next_prdata;
    reg next_err;

    always @* begin
        res_word = `ARBR_WORD_RESET;
        res_word[`ARBR_FULL_BIT] = (count == `ARBR_DEPTH); // RULE_05
        res_word[`ARBR_EMPTY_BIT] = (count_after == 7'h00); // RULE_06
        res_word[`ARBR_RSVD_BIT] = 1'b0; // RULE_07
        // Data bits stay zero on an empty read, no stale word leaks out
        if (count != 7'h00) begin
            res_word[12:0] = mem_rdata; // RULE_04
        end
    end

    always @* begin
        next_prdata = 32'h00000000;
        next_err = 1'b0;
        case (paddr)
            `ARBR_ADDR_RESULT: next_prdata = pwrite ? 32'h00000000 : {16'h0000, res_word};
            `ARBR_ADDR_CTRL: next_prdata = {31'h00000000, mode_en};
            `ARBR_ADDR_STATUS: next_prdata = {28'h0000000, irq_status};
            `ARBR_ADDR_MASK: next_prdata = {28'h0000000, irq_mask};
            `ARBR_ADDR_LEVEL: next_prdata = {25'h0000000, count};
            default: next_err = 1'b1;
        endcase
        if (pwrite) begin
            next_prdata = 32'h00000000;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ap_phase <= AP_IDLE;
            pready <= 1'b0;
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
            mode_en <= 1'b0;
            irq_mask <= 4'h0;
        end else if (ce) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            case (ap_phase)
                AP_IDLE: begin
                    if (psel && penable) begin
                        ap_phase <= AP_WAIT;
                    end
                end
                AP_WAIT: begin
                    ap_phase <= AP_FETCH;
                end
                AP_FETCH: begin
                    pready <= 1'b1;
                    prdata <= next_prdata;
                    pslverr <= next_err;
                    ap_phase <= AP_DONE;
                end
                AP_DONE: begin
                    ap_phase <= AP_IDLE;
                end
                default: ap_phase <= AP_IDLE;
            endcase
            if (wr_ctrl) begin
                mode_en <= pwdata[`ARBR_CTRL_MODE_BIT];
            end
            if (wr_mask) begin
                irq_mask <= pwdata[3:0];
            end
        end
    end

    // ==========================================
    // Pointers and fill level
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_ptr <= 6'h00;
            rd_ptr <= 6'h00;
            count <= 7'h00; // RULE_01
        end else if (ce) begin
            if (push) begin
                wr_ptr <= wr_ptr + 6'h01;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 6'h01; // RULE_14
            end
            // Push and pop never share a cycle: pushes wait while a read is open
            count <= count + {6'h00, push} - {6'h00, pop};
        end
    end

    // ==========================================
    // Interrupts
    wire [3:0] ev;
    assign ev[`ARBR_IRQ_PUSH] = push;
    assign ev[`ARBR_IRQ_FULL] = push && (count == `ARBR_DEPTH - 7'h01);
    assign ev[`ARBR_IRQ_DRAIN] = pop && (count_after == 7'h00);
    // A result offered while the sequencer is busy would be lost if the source ignores ready
    assign ev[`ARBR_IRQ_LOST] = res_valid && mode_en && (!conv_ready || slot_valid[res_source]);

    wire [3:0] stat_clr = wr_stat ? pwdata[3:0] : 4'h0;
    // Set beats clear so an event in the clearing cycle survives
    wire [3:0] next_status = (irq_status & ~stat_clr) | ev;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_status <= 4'h0;
            irq <= 1'b0;
        end else if (ce) begin
            irq_status <= next_status;
            irq <= |(next_status & (wr_mask ? pwdata[3:0] : irq_mask));
        end
    end

endmodule

`default_nettype wire

// ### dv/arbr_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Port checks
module arbr_asserts (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Converter and interrupt
    input wire logic conv_done,
    input wire logic conv_ready,
    input wire logic irq
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_wait;
        !pready [*3] ##1 pready;
    endsequence
    sequence s_flush;
        !conv_ready [*8];
    endsequence
    a_fixed_wait: assert property ($rose(psel && penable) |-> s_wait)
        else $error("pready latency wrong");
    a_one_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_err_only: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("pslverr without pready or with data");
    a_err_unmapped: assert property (pready && paddr > 12'h010 |-> pslverr)
        else $error("unmapped address not refused");
    a_mapped_ok: assert property (pready && paddr <= 12'h010 && paddr[1:0] == 2'h0 |-> !pslverr)
        else $error("mapped address refused");
    a_word_shape: assert property (pready && !pwrite && paddr == 12'h000 |->
        prdata[31:16] == 16'h0 && !(prdata[15] && prdata[14]))
        else $error("result word flags inconsistent");
    a_flush_span: assert property (conv_done && conv_ready |=> s_flush)
        else $error("flush shorter than eight slots");
    a_mask_off: assert property (pready && pwrite && paddr == 12'h00C && pwdata == 32'h0 |=> !irq)
        else $error("irq stays high with all masked");
endmodule
`default_nettype wire

// ### dv/arbr_host.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Host model, APB master
module arbr_host (
    // Clock
    input wire logic pclk,
    // APB master
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    logic [31:0] rdata;
    logic rerr;
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h0;
        pwdata = 32'h0;
    end
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        begin
            @(posedge pclk);
            psel <= 1'b1;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge pclk);
            penable <= 1'b1;
            do @(posedge pclk); while (pready !== 1'b1);
            rdata = prdata;
            rerr = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
            // Released lines show garbage so stale values are never trusted
            paddr <= ~a;
            pwdata <= ~d;
        end
    endtask
endmodule
`default_nettype wire

// ### dv/arbr_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "arbr_consts.vh"
bind arbr_top arbr_asserts arbr_asserts_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .conv_done(conv_done), .conv_ready(conv_ready),
    .irq(irq));
// ==========================================
// Bench top
module arbr_top_tb;
    logic pclk, presetn, ce, res_valid, conv_done;
    logic [11:0] res_value;
    logic [2:0] res_source, conv_type;
    wire logic psel, penable, pwrite, pready, pslverr, conv_ready, irq;
    wire logic [11:0] paddr;
    wire logic [31:0] pwdata, prdata;
    int failures, checks, i;
    arbr_top arbr_top_inst (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .res_valid(res_valid), .res_source(res_source),
        .res_value(res_value), .conv_type(conv_type), .conv_done(conv_done),
        .conv_ready(conv_ready), .irq(irq));
    arbr_host arbr_host_inst (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    // ==========================================
    // Tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        begin
            checks++;
            if (got !== exp) begin
                failures++;
                $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        begin
            arbr_host_inst.xfer(1'b0, a, 32'h0);
            chk(arbr_host_inst.rdata, exp);
        end
    endtask
    task automatic sync;
        int n = 0;
        begin
            @(posedge pclk);
            while (conv_ready !== 1'b1 && n < 500) begin
                @(posedge pclk);
                n++;
            end
            if (n == 500) chk(32'h0, 32'h1);
        end
    endtask
    task automatic res(input logic [2:0] s, input logic [11:0] v);
        begin
            sync();
            res_valid <= 1'b1;
            res_source <= s;
            res_value <= v;
            @(posedge pclk);
            res_valid <= 1'b0;
            res_source <= ~s;
            res_value <= ~v;
        end
    endtask
    task automatic done(input logic [2:0] t);
        begin
            @(posedge pclk);
            conv_type <= t;
            conv_done <= 1'b1;
            @(posedge pclk);
            conv_done <= 1'b0;
        end
    endtask
    // Push order and expected order are packed three bits a slot, slot 0 low
    task automatic grp(input logic [2:0] t, input logic [23:0] p, input logic [23:0] e,
        input int n);
        logic [2:0] s;
        begin
            for (int k = 0; k < n; k++) res(p[3*k+:3], {1'b1, p[3*k+:3], 8'h5A});
            done(t);
            sync();
            for (int k = 0; k < n; k++) begin
                s = e[3*k+:3];
                rd(`ARBR_ADDR_RESULT, {16'h0, 1'b0, k == n - 1, 1'b0, s[0], 1'b1, s, 8'h5A});
            end
        end
    endtask
    task automatic close_out;
        begin
            if (failures == 0 && checks > 0) $display("[ PASS ]");
            else $display("[ FAIL ]");
            $finish;
        end
    endtask
    // ==========================================
    // Tests
    initial begin
        failures = 0;
        checks = 0;
        presetn = 1'b0;
        ce = 1'b1;
        res_valid = 1'b0;
        conv_done = 1'b0;
        res_source = 3'h0;
        res_value = 12'h0;
        conv_type = 3'h0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        rd(`ARBR_ADDR_RESULT, 32'h4000);
        res(`ARBR_SRC_X, 12'h123);
        done(`ARBR_CONV_SINGLE);
        arbr_host_inst.xfer(1'b1, `ARBR_ADDR_RESULT, 32'hFFFF);
        rd(`ARBR_ADDR_RESULT, 32'h4000);
        rd(12'h020, 32'h0);
        chk({31'h0, arbr_host_inst.rerr}, 32'h1);
        arbr_host_inst.xfer(1'b1, `ARBR_ADDR_CTRL, 32'h1);
        grp(`ARBR_CONV_XY, 24'h000008, 24'h000001, 2);
        grp(`ARBR_CONV_XYZZ, 24'h000213, 24'h000681, 4);
        grp(`ARBR_CONV_ZZ, 24'h000013, 24'h00001A, 2);
        grp(`ARBR_CONV_AUTO, 24'h000177, 24'h0001F5, 3);
        grp(`ARBR_CONV_PORT, 24'h00012E, 24'h0001AC, 3);
        rd(`ARBR_ADDR_STATUS, 32'h5);
        chk({31'h0, irq}, 32'h0);
        arbr_host_inst.xfer(1'b1, `ARBR_ADDR_MASK, 32'h1);
        repeat (2) @(posedge pclk);
        chk({31'h0, irq}, 32'h1);
        arbr_host_inst.xfer(1'b1, `ARBR_ADDR_STATUS, 32'hF);
        repeat (2) @(posedge pclk);
        chk({31'h0, irq}, 32'h0);
        arbr_host_inst.xfer(1'b1, `ARBR_ADDR_MASK, 32'h0);
        // The last group stalls in the flush until the host frees a slot
        for (i = 0; i < 65; i++) begin
            res(`ARBR_SRC_X, 12'(i));
            done(`ARBR_CONV_SINGLE);
        end
        rd(`ARBR_ADDR_LEVEL, 32'h40);
        for (i = 0; i < 65; i++) begin
            if (i == 1) sync();
            rd(`ARBR_ADDR_RESULT, {16'h0, i < 2, i == 64, 2'h0, 12'(i)});
        end
        close_out;
    end
    initial begin
        #500000;
        failures++;
        close_out;
    end
endmodule
`default_nettype wire
